// file: rtl/tvd_params.svh
// Purpose: named widths, field positions and levels of the triple video converter front end
// Assumes: included by the package and by every design module
// Notes: levels are in converter steps of one colour code lsb
`ifndef TVD_PARAMS_SVH
`define TVD_PARAMS_SVH

`define TVD_WORD_W 10
`define TVD_LEVEL_W 11
`define TVD_FIFO_W 32
`define TVD_FIFO_DEPTH 32
`define TVD_FIFO_AW 5

// channel order in the converter stage
`define TVD_BLUE_CHAN 0
`define TVD_GREEN_CHAN 1
`define TVD_RED_CHAN 2
`define TVD_NCHAN 3

// packed fifo word layout
`define TVD_BLUE_LSB 0
`define TVD_GREEN_LSB 10
`define TVD_RED_LSB 20
`define TVD_SYNC_BIT 30
`define TVD_BLANK_BIT 31

// pedestal about 0.0540 V, sync source 40 IRE, both in code steps
`define TVD_PEDESTAL_LEVEL 11'h054
`define TVD_SYNC_LEVEL 11'h1bb
`define TVD_ZERO_LEVEL 11'h000
`define TVD_ZERO_WORD 10'h000

// fastest rated speed grade, in MHz
`define TVD_MAX_RATE_MHZ 80

`endif

// file: rtl/tvd_pkg.sv
// Purpose: shared types of the triple video converter front end
// Assumes: tvd_params.svh supplies the widths
// Notes: none
`include "tvd_params.svh"

package tvd_pkg;
  typedef logic [`TVD_WORD_W-1:0] tvd_word_t;
  typedef logic [`TVD_LEVEL_W-1:0] tvd_level_t;
  typedef logic [`TVD_FIFO_W-1:0] tvd_beat_t;
  typedef enum logic [1:0] {
    TVD_ACTIVE,
    TVD_BLANK,
    TVD_SYNC_TIP,
    TVD_UNDERRUN
  } tvd_mode_t;
endpackage

// file: rtl/tvd_fifo.sv
// Purpose: show-ahead fifo between the pixel source and the converter stage
// Assumes: one clock, synchronous active-high reset
// Notes: head word is read straight from the array, so a pop costs no latency
`timescale 1ns/1ps
`include "tvd_params.svh"

module tvd_fifo #(
  parameter int WIDTH = `TVD_FIFO_W,
  parameter int DEPTH = `TVD_FIFO_DEPTH,
  parameter int AW = `TVD_FIFO_AW
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire push;
  wire pop;
  wire full;
  wire empty;

  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign push = i_wr_valid && !full;
  assign pop = i_rd_ready && !empty;
  assign o_rd_data = mem[rd_ptr_q[AW-1:0]];

  // no reset on the array: contents are never read while empty
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // tvd_fifo

// file: rtl/tvd_front_end.sv
// Purpose: digital front end of a triple 10-bit video converter with sync and blank
// Assumes: pixel source runs on i_clk; i_convert paces the converter sample rate
// Notes: outputs are level codes in converter steps, one per channel current
//
// Behaviour
// - capture red, green, blue words together
// - three channels on one clock, green alone adds sync
// - exactly one register stage to outputs
// - sync and blank share pixel pipeline
// - blank low: data dropped, pedestal off, blanking
// - blank high: colour word plus pedestal
// - sync low switches sync source off
// - sync source adds to green only
// - both low: green at zero
`timescale 1ns/1ps
`include "tvd_params.svh"

module tvd_front_end (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire tvd_pkg::tvd_word_t i_red_pixel_word,
  input wire tvd_pkg::tvd_word_t i_green_pixel_word,
  input wire tvd_pkg::tvd_word_t i_blue_pixel_word,
  input wire logic i_sync_n,
  input wire logic i_blank_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic i_convert,
  output tvd_pkg::tvd_level_t o_red_current_out,
  output tvd_pkg::tvd_level_t o_green_current_out,
  output tvd_pkg::tvd_level_t o_blue_current_out,
  output logic o_sync_source_on,
  output logic o_pedestal_on,
  output tvd_pkg::tvd_mode_t o_mode,
  output logic o_underrun
);
  import tvd_pkg::*;

  // channel level: the pedestal lifts code zero above blanking, and the
  // colour code adds one step per count, so the ramp is linear and monotonic
  function automatic tvd_level_t chan_level(input tvd_word_t word, input logic blank_n);
    tvd_level_t lvl;
    lvl = `TVD_ZERO_LEVEL;
    if (blank_n) begin
      lvl = `TVD_PEDESTAL_LEVEL + {1'b0, word};
    end
    return lvl;
  endfunction

  // colour word of one channel inside a packed fifo beat
  function automatic tvd_word_t beat_word(input tvd_beat_t beat, input int chan);
    return beat[chan*`TVD_WORD_W +: `TVD_WORD_W];
  endfunction

  // picture mode of the taken beat; an empty fifo reads as underrun
  // sync low while active is the source's fault and still shows as active
  function automatic tvd_mode_t beat_mode(input logic taken, input logic blank_n,
      input logic sync_n);
    tvd_mode_t m;
    m = TVD_UNDERRUN;
    if (taken) begin
      if (blank_n) begin
        m = TVD_ACTIVE;
      end else if (sync_n) begin
        m = TVD_BLANK;
      end else begin
        m = TVD_SYNC_TIP;
      end
    end
    return m;
  endfunction

  // fifo word assembly and fields of the head word
  wire tvd_beat_t in_beat;
  tvd_beat_t head_beat;
  wire head_valid;
  wire take;

  assign in_beat[`TVD_RED_LSB +: `TVD_WORD_W] = i_red_pixel_word;
  assign in_beat[`TVD_GREEN_LSB +: `TVD_WORD_W] = i_green_pixel_word;
  assign in_beat[`TVD_BLUE_LSB +: `TVD_WORD_W] = i_blue_pixel_word;
  assign in_beat[`TVD_SYNC_BIT] = i_sync_n;
  assign in_beat[`TVD_BLANK_BIT] = i_blank_n;

  // all words of one pixel travel as one fifo beat, so they stay together
  // show-ahead, so the head pixel is popped in the cycle it is used
  // a full fifo holds the source off through o_ready; no pixel is lost
  tvd_fifo #(
    .WIDTH(`TVD_FIFO_W),
    .DEPTH(`TVD_FIFO_DEPTH),
    .AW(`TVD_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_data(in_beat),
    .i_wr_valid(i_valid),
    .o_wr_ready(o_ready),
    .o_rd_data(head_beat),
    .o_rd_valid(head_valid),
    .i_rd_ready(i_convert)
  );

  // a pixel is taken only when a sample is due and the fifo holds one
  // with i_convert low every output register except underrun_q holds its level
  assign take = i_convert && head_valid;

  // an underrun is shown as blanking with sync on, the quietest picture
  wire head_blank_n;
  wire head_sync_n;
  wire eff_blank_n;
  wire eff_sync_n;

  assign head_blank_n = head_beat[`TVD_BLANK_BIT];
  assign head_sync_n = head_beat[`TVD_SYNC_BIT];
  assign eff_blank_n = take ? head_blank_n : 1'b0;
  assign eff_sync_n = take ? head_sync_n : 1'b1;

  // per channel levels; index 0 blue, 1 green, 2 red
  wire tvd_level_t chan_d [`TVD_NCHAN];
  wire tvd_level_t chan_sync [`TVD_NCHAN];
  wire tvd_level_t chan_rst [`TVD_NCHAN];
  wire tvd_level_t chan_next [`TVD_NCHAN];
  tvd_level_t chan_q [`TVD_NCHAN];

  // sync source: on while sync is high, off for the sync tip
  wire sync_on_d;
  wire tvd_level_t green_sync_d;

  assign sync_on_d = eff_sync_n;
  // 40 IRE of sync is one fixed step stacked under the green level
  assign green_sync_d = sync_on_d ? `TVD_SYNC_LEVEL : `TVD_ZERO_LEVEL;

  genvar gi;
  generate
    for (gi = 0; gi < `TVD_NCHAN; gi++) begin : g_chan
      localparam bit IS_GREEN = (gi == `TVD_GREEN_CHAN);
      wire tvd_word_t head_word;
      wire tvd_word_t word;

      assign head_word = beat_word(head_beat, gi);
      // an empty fifo feeds code zero, which the blank gate then drops
      assign word = take ? head_word : `TVD_ZERO_WORD;
      // blanking drops the word and the pedestal together
      assign chan_d[gi] = chan_level(word, eff_blank_n);
      // the sync current lands on green alone; red and blue never see it
      assign chan_sync[gi] = IS_GREEN ? green_sync_d : `TVD_ZERO_LEVEL;
      // green rests at blanking plus sync after reset, the others at zero
      assign chan_rst[gi] = IS_GREEN ? `TVD_SYNC_LEVEL : `TVD_ZERO_LEVEL;
      assign chan_next[gi] = chan_d[gi] + chan_sync[gi];

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          chan_q[gi] <= chan_rst[gi];
        end else if (i_convert) begin
          chan_q[gi] <= chan_next[gi];
        end
      end
    end
  endgenerate

  // sync and pedestal flags ride the same stage as the levels
  logic sync_on_q;
  logic pedestal_q;
  logic underrun_q;
  tvd_mode_t mode_q;
  wire pedestal_d;
  wire underrun_d;
  wire tvd_mode_t mode_d;

  assign pedestal_d = eff_blank_n;
  assign underrun_d = i_convert && !head_valid;
  // sync does not override data; the source keeps it low only while blanked
  assign mode_d = beat_mode(take, head_blank_n, head_sync_n);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_on_q <= 1'b1;
    end else if (i_convert) begin
      sync_on_q <= sync_on_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pedestal_q <= 1'b0;
    end else if (i_convert) begin
      pedestal_q <= pedestal_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= TVD_UNDERRUN;
    end else if (i_convert) begin
      mode_q <= mode_d;
    end
  end

  // one pulse per starved sample, so a stalled source shows up at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      underrun_q <= 1'b0;
    end else begin
      underrun_q <= underrun_d;
    end
  end

  // outputs come straight from the stage registers, no logic after them
  assign o_red_current_out = chan_q[`TVD_RED_CHAN];
  assign o_green_current_out = chan_q[`TVD_GREEN_CHAN];
  assign o_blue_current_out = chan_q[`TVD_BLUE_CHAN];
  assign o_sync_source_on = sync_on_q;
  assign o_pedestal_on = pedestal_q;
  assign o_mode = mode_q;
  assign o_underrun = underrun_q;

  // the rate limit of the speed grade is the pixel source's concern and is
  // paced here only through i_convert
endmodule // tvd_front_end

// file: testbench/tvd_monitor.sv
// Purpose: port checks of the video converter front end
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every front end instance
`timescale 1ns/1ps
`include "tvd_params.svh"
module tvd_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire tvd_pkg::tvd_word_t i_red_pixel_word,
  input wire tvd_pkg::tvd_word_t i_green_pixel_word,
  input wire tvd_pkg::tvd_word_t i_blue_pixel_word,
  input wire logic i_sync_n,
  input wire logic i_blank_n,
  input wire logic i_valid,
  input wire logic o_ready,
  input wire logic i_convert,
  input wire tvd_pkg::tvd_level_t o_red_current_out,
  input wire tvd_pkg::tvd_level_t o_green_current_out,
  input wire tvd_pkg::tvd_level_t o_blue_current_out,
  input wire logic o_sync_source_on,
  input wire logic o_pedestal_on,
  input wire tvd_pkg::tvd_mode_t o_mode,
  input wire logic o_underrun
);
  import tvd_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_blank_rb_zero: assert property (!o_pedestal_on |-> o_red_current_out == 0
    && o_blue_current_out == 0) else $error("red or blue off blank level");
  a_pedestal_floor: assert property (o_pedestal_on |->
    o_red_current_out >= `TVD_PEDESTAL_LEVEL) else $error("red below pedestal");
  a_green_sync_add: assert property (!o_pedestal_on |-> o_green_current_out ==
    (o_sync_source_on ? `TVD_SYNC_LEVEL : 0)) else $error("green blank level wrong");
  a_sync_tip_zero: assert property (o_mode == TVD_SYNC_TIP |->
    o_green_current_out == 0 && !o_sync_source_on) else $error("sync tip not zero");
  a_hold_idle: assert property (!i_convert |=> $stable(o_red_current_out)
    && $stable(o_green_current_out) && $stable(o_mode)) else $error("output moved");
  a_underrun_cause: assert property (o_underrun |-> $past(i_convert)
    && o_mode == TVD_UNDERRUN) else $error("underrun without convert");
  a_active_mode: assert property (o_mode == TVD_ACTIVE |->
    o_pedestal_on && o_sync_source_on) else $error("active mode flags wrong");
  a_blue_on_convert: assert property ($changed(o_blue_current_out) |->
    $past(i_convert)) else $error("blue changed off convert");
  c_underrun: cover property (o_underrun);
  c_sync_tip: cover property (o_mode == TVD_SYNC_TIP);
  c_full_pop: cover property (!o_ready && i_convert);
endmodule // tvd_monitor
bind tvd_front_end tvd_monitor tvd_monitor_inst (.*);

// file: testbench/tvd_pixel_src.sv
// Purpose: pixel source model on the push side
// Assumes: pushes land on rising edges of i_clk
// Notes: i_en low stops new pixels; a held pixel stays offered
`timescale 1ns/1ps
module tvd_pixel_src (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_ready,
  output tvd_pkg::tvd_word_t o_red,
  output tvd_pkg::tvd_word_t o_green,
  output tvd_pkg::tvd_word_t o_blue,
  output logic o_sync_n,
  output logic o_blank_n,
  output logic o_valid
);
  logic acc;
  initial {o_valid, o_red, o_green, o_blue, o_sync_n, o_blank_n} = '0;
  always @(posedge i_clk) begin
    acc = o_valid && i_ready;
    #1;
    if (acc || !o_valid) begin
      o_valid = i_en && ($urandom % 4 != 0);
      {o_red, o_green, o_blue} = o_valid ? (($urandom % 4 == 0) ? {30{1'($urandom)}}
        : 30'($urandom)) : ~{o_red, o_green, o_blue};
      o_blank_n = ($urandom % 4 != 0);
      o_sync_n = o_blank_n || 1'($urandom);
    end
  end
endmodule // tvd_pixel_src

// file: testbench/tvd_front_end_tb.sv
// Purpose: self-checking bench for the video converter front end
// Assumes: pixel source model drives the push side
// Notes: a queue model predicts each converter stage
`timescale 1ns/1ps
`include "tvd_params.svh"
module tvd_front_end_tb;
  import tvd_pkg::*;
  logic clk, rst, rs, en, cv, sy, bl, vld, rdy, syo, pdo, und, e_s, e_p, e_u;
  tvd_word_t r, g, b;
  tvd_level_t ro, go, bo, e_r, e_g, e_b;
  tvd_mode_t mo, e_m;
  logic [31:0] q[$];
  logic [31:0] bt;
  int bad_count, tests_run;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  tvd_pixel_src tvd_pixel_src_inst (.i_clk(clk), .i_en(en), .i_ready(rdy), .o_red(r),
    .o_green(g), .o_blue(b), .o_sync_n(sy), .o_blank_n(bl), .o_valid(vld));
  tvd_front_end tvd_front_end_inst (.i_clk(clk), .i_rst(rst), .i_red_pixel_word(r),
    .i_green_pixel_word(g), .i_blue_pixel_word(b), .i_sync_n(sy), .i_blank_n(bl),
    .i_valid(vld), .o_ready(rdy), .i_convert(cv), .o_red_current_out(ro),
    .o_green_current_out(go), .o_blue_current_out(bo), .o_sync_source_on(syo),
    .o_pedestal_on(pdo), .o_mode(mo), .o_underrun(und));
  task chk(string n, logic [10:0] e, logic [10:0] v);
    tests_run++;
    if (v !== e) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", n, e, v);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    rs = rst;
    e_u = !rs && cv && q.size() == 0;
    if (rs) q.delete();
    if (rs || e_u) begin
      {e_r, e_b, e_p, e_s} = 24'h1;
      e_g = `TVD_SYNC_LEVEL;
      e_m = TVD_UNDERRUN;
    end else if (cv) begin
      bt = q.pop_front();
      {e_p, e_s} = bt[31:30];
      e_r = e_p ? `TVD_PEDESTAL_LEVEL + bt[29:20] : 0;
      e_b = e_p ? `TVD_PEDESTAL_LEVEL + bt[9:0] : 0;
      e_g = (e_p ? `TVD_PEDESTAL_LEVEL + bt[19:10] : 0) + (e_s ? `TVD_SYNC_LEVEL : 0);
      e_m = e_p ? TVD_ACTIVE : e_s ? TVD_BLANK : TVD_SYNC_TIP;
    end
    if (!rs && vld && rdy) q.push_back({bl, sy, r, g, b});
    #2;
    if (!rs) begin
      chk("red", e_r, ro);
      chk("green", e_g, go);
      chk("blue", e_b, bo);
      chk("sync", e_s, syo);
      chk("pedestal", e_p, pdo);
      chk("mode", e_m, mo);
      chk("underrun", e_u, und);
      chk("ready", 11'(q.size() < `TVD_FIFO_DEPTH), rdy);
    end
  end
  initial begin
    void'($urandom(23621));
    {rst, en, cv} = 3'b100;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    en = 1;
    for (int i = 0; i < 200 && rdy; i++) @(posedge clk) #1;
    chk("fill", 32, 11'(q.size()));
    repeat (4) @(posedge clk);
    #1 en = 0;
    cv = 1;
    repeat (40) @(posedge clk);
    #1 en = 1;
    repeat (3000) begin
      @(posedge clk);
      #1 cv = ($urandom % 3 != 0);
    end
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (50) @(posedge clk);
    final_report;
  end
  initial begin
    #40000;
    bad_count++;
    final_report;
  end
endmodule // tvd_front_end_tb
